// ### inc/mailbox_pkg.sv
// constants, types and helpers shared by the mailbox responder and its checksum engine
package mailbox_pkg;

  // ----------------------------------------
  // command codes and frame lengths
  // ----------------------------------------
  localparam logic [7:0] CMD_REQUEST = 8'hd1;
  localparam logic [7:0] CMD_RESPONSE = 8'hd5;
  localparam logic [3:0] REQ_WR_LEN = 4'h7; // command code, type, four data bytes, checksum
  localparam logic [3:0] RSP_WR_LEN = 4'h2; // command code, transaction id
  localparam logic [3:0] REQ_RD_LEN = 4'h1;
  localparam logic [3:0] RSP_RD_LEN = 4'h5;
  localparam logic [3:0] WR_COUNT_MAX = 4'hf;

  // write byte positions within a frame
  localparam logic [3:0] IDX_CMD = 4'h0;
  localparam logic [3:0] IDX_TYPE = 4'h1; // also the transaction id of a response command
  localparam logic [3:0] IDX_DATA = 4'h2;
  localparam logic [3:0] IDX_AWCS = 4'h6;

  // ----------------------------------------
  // completion codes
  // ----------------------------------------
  localparam logic [7:0] CC_PASS = 8'h40;
  localparam logic [3:0] CC_GRANT_HI = 4'h4;
  localparam logic [7:0] CC_TIMEOUT = 8'h80;
  localparam logic [7:0] CC_BAD_THERMAL_CFG = 8'h81;
  localparam logic [7:0] CC_BAD_STATUS_MASK = 8'h82;
  localparam logic [7:0] CC_BAD_COUNTER = 8'h83;
  localparam logic [7:0] CC_BAD_BANK = 8'h84;
  localparam logic [7:0] CC_BAD_TID = 8'h85;
  localparam logic [7:0] CC_BUSY = 8'h86;
  localparam logic [7:0] CC_BANK_UNAVAIL = 8'h88;
  localparam logic [7:0] CC_BAD_CORE = 8'h89;
  localparam logic [7:0] CC_UNKNOWN_TYPE = 8'hff;
  localparam logic [7:0] TID_MAX = 8'h0f;

  // ----------------------------------------
  // checksum and timing
  // ----------------------------------------
  localparam logic [7:0] CRC_POLY = 8'h07;
  localparam logic [7:0] CRC_INIT = 8'h00;
  localparam int CLK_PERIOD_NS = 40;
  localparam int LOCK_TIMEOUT_NS = 1000000;
  localparam int LOCK_TIMEOUT_CYCLES = LOCK_TIMEOUT_NS / CLK_PERIOD_NS;

  // ----------------------------------------
  // types
  // ----------------------------------------
  typedef enum logic [2:0] {
    SVC_OK = 3'b000,
    SVC_BAD_THERMAL_CFG = 3'b001,
    SVC_BAD_STATUS_MASK = 3'b010,
    SVC_BAD_COUNTER = 3'b011,
    SVC_BAD_BANK = 3'b100,
    SVC_BANK_UNAVAIL = 3'b101,
    SVC_BAD_CORE = 3'b110,
    SVC_UNKNOWN_TYPE = 3'b111
  } svc_status_t;

  typedef enum logic [1:0] {
    PH_IDLE = 2'b00,
    PH_WRITE = 2'b01,
    PH_ANSWER = 2'b10
  } phase_t;

  // one byte of the frame checksum, most significant bit first
  function automatic logic [7:0] crc8_step(input logic [7:0] crc, input logic [7:0] data);
    logic [7:0] c;
    c = crc ^ data;
    for (int i = 0; i < 8; i++)
    begin
      c = c[7] ? ((c << 1) ^ CRC_POLY) : (c << 1);
    end
    return c;
  endfunction

  // completion code for the outcome of a serviced request
  function automatic logic [7:0] cc_of(input svc_status_t s);
    logic [7:0] cc;
    cc = CC_UNKNOWN_TYPE;
    unique case (s)
      SVC_OK: cc = CC_PASS;
      SVC_BAD_THERMAL_CFG: cc = CC_BAD_THERMAL_CFG;
      SVC_BAD_STATUS_MASK: cc = CC_BAD_STATUS_MASK;
      SVC_BAD_COUNTER: cc = CC_BAD_COUNTER;
      SVC_BAD_BANK: cc = CC_BAD_BANK;
      SVC_BANK_UNAVAIL: cc = CC_BANK_UNAVAIL;
      SVC_BAD_CORE: cc = CC_BAD_CORE;
      SVC_UNKNOWN_TYPE: cc = CC_UNKNOWN_TYPE;
    endcase
    return cc;
  endfunction

endpackage

// ### core/checksum_engine.sv
// running frame checksum over the write bytes of a command
`timescale 1ns/1ns
`default_nettype none
module checksum_engine (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic clear,
  input wire logic data_valid,
  input wire logic [7:0] data_byte,
  output logic [7:0] crc
);
  import mailbox_pkg::*;

  logic [7:0] next_crc;

  // restart at each frame, fold in each byte
  always_comb
  begin
    next_crc = crc;
    if (clear)
      next_crc = CRC_INIT;
    else if (data_valid)
      next_crc = crc8_step(crc, data_byte);
  end

  always_ff @(posedge clk)
  begin
    if (!reset_n)
      crc <= CRC_INIT;
    else
      crc <= next_crc;
  end
endmodule
`default_nettype wire

// ### core/mailbox_responder.sv
// device end of the lockable mailbox: request and response commands
`timescale 1ns/1ns
`default_nettype none
// How it works
// RULE1 - request: code d1, seven writes, one read
// RULE2 - checksum mismatch discards write, answers abort
// RULE3 - four-byte words travel low byte first
// RULE4 - lock grant answers 0x4 plus id
// RULE5 - reset or sleep answers code 0x80
// RULE6 - unavailable or held mailbox answers 0x86
// RULE7 - host treats bad answer checksum as unknown
// RULE8 - host sends granted id in response command
// RULE9 - wrong or unlocked id answers 0x85
// RULE10 - matching id answers 0x40 with data
// RULE11 - response: code d5, two writes, five reads
// RULE12 - response command carries no write checksum
// RULE13 - result not ready aborts, host retries
// RULE14 - service failures 0x81 to 0x84 reported
// RULE15 - failures 0x88, 0x89, 0xff reported
// RULE16 - lock commits only after final read bit
// RULE17 - release only after final read bit
// RULE18 - held lock refuses new requests as busy
// RULE19 - 1ms link low time clears lock
// RULE20 - one transaction, latched request, held result
module mailbox_responder #(
  parameter int TIMEOUT_CYCLES = mailbox_pkg::LOCK_TIMEOUT_CYCLES
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic frame_start,
  input wire logic wr_valid,
  input wire logic [7:0] wr_byte,
  input wire logic wr_end,
  input wire logic rd_take,
  input wire logic frame_commit,
  input wire logic frame_abort,
  output logic [7:0] rd_data,
  output logic rd_valid,
  output logic abort_fcs,
  output logic svc_req,
  output logic [7:0] svc_type,
  output logic [31:0] svc_payload,
  input wire logic svc_done,
  input wire mailbox_pkg::svc_status_t svc_status,
  input wire logic [31:0] svc_data,
  input wire logic mbx_unavailable,
  input wire logic reset_or_sleep,
  input wire logic timeout_disable,
  input wire logic link_low,
  output logic locked,
  output logic [3:0] tid
);
  import mailbox_pkg::*;

  localparam int LOW_W = $clog2(TIMEOUT_CYCLES + 1);

  // ----------------------------------------
  // state
  // ----------------------------------------
  phase_t phase, next_phase;
  logic [3:0] wr_count, next_wr_count;
  logic [7:0] cmd, next_cmd;
  logic [7:0] req_type, next_req_type;
  logic [31:0] payload, next_payload;
  logic [7:0] tid_byte, next_tid_byte;
  logic aw_ok, next_aw_ok;
  logic [39:0] resp_shift, next_resp_shift;
  logic next_rd_valid, next_abort_fcs;
  logic grant_pending, next_grant_pending;
  logic release_pending, next_release_pending;
  logic next_locked;
  logic [3:0] next_tid;
  logic result_ready, next_result_ready;
  logic [7:0] result_cc, next_result_cc;
  logic [31:0] result_data, next_result_data;
  logic next_svc_req;
  logic [7:0] next_svc_type;
  logic [31:0] next_svc_payload;
  logic [LOW_W-1:0] low_count, next_low_count;
  logic link_low_meta, link_low_sync;
  logic [7:0] crc_now;
  logic is_req, is_rsp, timed_out;

  // ----------------------------------------
  // link level synchroniser and checksum
  // ----------------------------------------
  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      link_low_meta <= 1'b0;
      link_low_sync <= 1'b0;
    end
    else
    begin
      link_low_meta <= link_low;
      link_low_sync <= link_low_meta;
    end
  end

  checksum_engine u_checksum (
    .clk(clk),
    .reset_n(reset_n),
    .clear(frame_start),
    .data_valid(wr_valid && phase == PH_WRITE),
    .data_byte(wr_byte),
    .crc(crc_now)
  );

  // frame shape and lock timeout decode
  assign is_req = cmd == CMD_REQUEST && wr_count == REQ_WR_LEN; // RULE1
  assign is_rsp = cmd == CMD_RESPONSE && wr_count == RSP_WR_LEN; // RULE11 RULE12
  assign timed_out = locked && link_low_sync && !timeout_disable
    && low_count == LOW_W'(TIMEOUT_CYCLES - 1); // RULE19
  assign rd_data = resp_shift[7:0];

  // ----------------------------------------
  // command engine
  // ----------------------------------------
  always_comb
  begin
    next_phase = phase;
    next_wr_count = wr_count;
    next_cmd = cmd;
    next_req_type = req_type;
    next_payload = payload;
    next_tid_byte = tid_byte;
    next_aw_ok = aw_ok;
    next_resp_shift = resp_shift;
    next_rd_valid = rd_valid;
    next_abort_fcs = abort_fcs;
    next_grant_pending = grant_pending;
    next_release_pending = release_pending;
    next_locked = locked;
    next_tid = tid;
    next_result_ready = result_ready;
    next_result_cc = result_cc;
    next_result_data = result_data;
    next_svc_req = 1'b0;
    next_svc_type = svc_type;
    next_svc_payload = svc_payload;
    next_low_count = low_count;
    // cumulative low time while the lock is held
    if (locked && link_low_sync && !timeout_disable)
      next_low_count = low_count + 1'b1;
    if (timed_out)
    begin
      next_locked = 1'b0; // RULE19
      next_low_count = '0;
    end
    // hold the serviced result for the response command
    if (svc_done && locked && !result_ready)
    begin
      next_result_ready = 1'b1; // RULE20
      next_result_cc = cc_of(svc_status); // RULE14 RULE15
      next_result_data = svc_data;
    end
    if (frame_start)
    begin
      next_phase = PH_WRITE;
      next_wr_count = '0;
      next_aw_ok = 1'b0;
      next_rd_valid = 1'b0;
      next_abort_fcs = 1'b0;
      next_grant_pending = 1'b0; // RULE16
      next_release_pending = 1'b0; // RULE17
    end
    else
    begin
      unique case (phase)
        PH_IDLE:
        begin
        end
        PH_WRITE:
        begin
          if (wr_valid)
          begin
            if (wr_count != WR_COUNT_MAX)
              next_wr_count = wr_count + 1'b1;
            if (wr_count == IDX_CMD)
              next_cmd = wr_byte;
            if (wr_count == IDX_TYPE)
            begin
              next_req_type = wr_byte;
              next_tid_byte = wr_byte;
            end
            if (wr_count >= IDX_DATA && wr_count < IDX_AWCS)
              next_payload = {wr_byte, payload[31:8]}; // RULE3
            if (wr_count == IDX_AWCS)
              next_aw_ok = wr_byte == crc_now; // RULE2
          end
          else if (wr_end)
          begin
            next_phase = PH_ANSWER;
            next_rd_valid = 1'b1;
            next_resp_shift = {32'h0, CC_TIMEOUT};
            if (!(is_req || is_rsp) || (is_req && !aw_ok))
              next_abort_fcs = 1'b1; // RULE2
            else if (reset_or_sleep)
              next_resp_shift = {32'h0, CC_TIMEOUT}; // RULE5
            else if (mbx_unavailable || (is_req && locked))
              next_resp_shift = {32'h0, CC_BUSY}; // RULE6 RULE18
            else if (is_req)
            begin
              next_resp_shift = {32'h0, CC_GRANT_HI, tid + 4'h1}; // RULE4
              next_grant_pending = 1'b1;
            end
            else if (tid_byte > TID_MAX || !locked || tid_byte[3:0] != tid)
              next_resp_shift = {32'h0, CC_BAD_TID}; // RULE9
            else if (!result_ready)
              next_abort_fcs = 1'b1; // RULE13
            else
            begin
              next_resp_shift = {result_data, result_cc}; // RULE10 RULE3
              next_release_pending = 1'b1;
            end
          end
        end
        PH_ANSWER:
        begin
          if (frame_abort || frame_commit)
          begin
            next_phase = PH_IDLE;
            next_rd_valid = 1'b0;
            next_abort_fcs = 1'b0;
            next_grant_pending = 1'b0;
            next_release_pending = 1'b0;
          end
          else if (rd_take)
            next_resp_shift = {8'h00, resp_shift[39:8]}; // RULE3
          if (frame_commit && grant_pending)
          begin
            next_locked = 1'b1; // RULE16
            next_tid = tid + 4'h1;
            next_svc_req = 1'b1; // RULE20
            next_svc_type = req_type;
            next_svc_payload = payload;
            next_result_ready = 1'b0;
            next_low_count = '0;
          end
          if (frame_commit && release_pending)
          begin
            next_locked = 1'b0; // RULE17 RULE11
            next_result_ready = 1'b0;
            next_low_count = '0;
          end
        end
        default:
          next_phase = PH_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      phase <= PH_IDLE;
      wr_count <= '0;
      cmd <= 8'h00;
      req_type <= 8'h00;
      payload <= 32'h0;
      tid_byte <= 8'h00;
      aw_ok <= 1'b0;
      resp_shift <= 40'h0;
      rd_valid <= 1'b0;
      abort_fcs <= 1'b0;
      grant_pending <= 1'b0;
      release_pending <= 1'b0;
      locked <= 1'b0;
      tid <= 4'h0;
      result_ready <= 1'b0;
      result_cc <= 8'h00;
      result_data <= 32'h0;
      svc_req <= 1'b0;
      svc_type <= 8'h00;
      svc_payload <= 32'h0;
      low_count <= '0;
    end
    else
    begin
      phase <= next_phase;
      wr_count <= next_wr_count;
      cmd <= next_cmd;
      req_type <= next_req_type;
      payload <= next_payload;
      tid_byte <= next_tid_byte;
      aw_ok <= next_aw_ok;
      resp_shift <= next_resp_shift;
      rd_valid <= next_rd_valid;
      abort_fcs <= next_abort_fcs;
      grant_pending <= next_grant_pending;
      release_pending <= next_release_pending;
      locked <= next_locked;
      tid <= next_tid;
      result_ready <= next_result_ready;
      result_cc <= next_result_cc;
      result_data <= next_result_data;
      svc_req <= next_svc_req;
      svc_type <= next_svc_type;
      svc_payload <= next_svc_payload;
      low_count <= next_low_count;
    end
  end

  // ----------------------------------------
  // checks
  // ----------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  sequence s_decide;
    phase == PH_WRITE && wr_end && !frame_start && !wr_valid;
  endsequence
  sequence s_req_ok;
    s_decide ##0 is_req && aw_ok && !reset_or_sleep;
  endsequence

  property p_bad_checksum;
    s_decide ##0 is_req && !aw_ok |=> abort_fcs && rd_valid && !grant_pending;
  endproperty
  a_bad_checksum: assert property (p_bad_checksum) else $error("bad checksum not aborted"); // RULE2

  property p_grant_code;
    s_req_ok ##0 !locked && !mbx_unavailable |=> rd_data[7:4] == CC_GRANT_HI && rd_data[3:0] == $past(tid) + 4'h1;
  endproperty
  a_grant_code: assert property (p_grant_code) else $error("grant code wrong"); // RULE4

  property p_busy;
    s_req_ok ##0 locked |=> rd_data == CC_BUSY && !grant_pending;
  endproperty
  a_busy: assert property (p_busy) else $error("held lock not refused"); // RULE18

  property p_sleep;
    s_decide ##0 (is_rsp || (is_req && aw_ok)) && reset_or_sleep |=> rd_data == CC_TIMEOUT && !abort_fcs;
  endproperty
  a_sleep: assert property (p_sleep) else $error("reset or sleep code wrong"); // RULE5

  property p_bad_tid;
    s_decide ##0 is_rsp && !reset_or_sleep && !mbx_unavailable && !locked |=> rd_data == CC_BAD_TID;
  endproperty
  a_bad_tid: assert property (p_bad_tid) else $error("unlocked id not refused"); // RULE9

  property p_not_ready;
    s_decide ##0 is_rsp && !reset_or_sleep && !mbx_unavailable && locked && tid_byte == {4'h0, tid}
      && !result_ready |=> abort_fcs && !release_pending;
  endproperty
  a_not_ready: assert property (p_not_ready) else $error("unready result not aborted"); // RULE13

  property p_lock_on_commit;
    $rose(locked) |-> $past(frame_commit) && $past(grant_pending) && svc_req;
  endproperty
  a_lock_on_commit: assert property (p_lock_on_commit) else $error("lock taken without commit"); // RULE16

  property p_release;
    $fell(locked) |-> ($past(frame_commit) && $past(release_pending)) || $past(timed_out);
  endproperty
  a_release: assert property (p_release) else $error("lock dropped without cause"); // RULE17

  property p_timeout;
    timed_out && !frame_commit |=> !locked ##1 (!locked || svc_req);
  endproperty
  a_timeout: assert property (p_timeout) else $error("lock timeout did not clear"); // RULE19

  property p_byte_order;
    phase == PH_ANSWER && rd_take && !frame_commit && !frame_abort && !frame_start
      |=> rd_data == $past(resp_shift[15:8]);
  endproperty
  a_byte_order: assert property (p_byte_order) else $error("answer bytes out of order"); // RULE3
endmodule
`default_nettype wire

// ### testbench/host_model.sv
// host controller model that originates mailbox frames
`timescale 1ns/1ns
`default_nettype none
module host_model (
  input wire logic clk,
  output logic frame_start,
  output logic wr_valid,
  output logic [7:0] wr_byte,
  output logic wr_end,
  output logic rd_take,
  output logic frame_commit,
  output logic frame_abort,
  output logic link_low,
  input wire logic [7:0] rd_data,
  input wire logic rd_valid,
  input wire logic abort_fcs
);
  // idle link: no frame, wire high
  initial
  begin
    {frame_start, wr_valid, wr_end, rd_take, frame_commit, frame_abort, link_low} = '0;
    wr_byte = 8'h00;
  end

  // one whole frame: write bytes low index first, read bytes, then finish or give up
  task automatic frame(input logic [63:0] wb, input int nwr, input int nrd, input logic commit,
    output logic [39:0] rb, output logic ab, output logic vld);
    rb = '0;
    @(posedge clk);
    frame_start <= 1'b1;
    for (int i = 0; i < nwr; i++)
    begin
      @(posedge clk);
      frame_start <= 1'b0;
      wr_valid <= 1'b1;
      wr_byte <= wb[8*i +: 8];
    end
    @(posedge clk);
    wr_valid <= 1'b0;
    wr_byte <= ~wr_byte; // released lane shows no stale byte
    wr_end <= 1'b1;
    @(posedge clk);
    wr_end <= 1'b0;
    @(posedge clk);
    ab = abort_fcs;
    vld = rd_valid;
    rb[7:0] = rd_data;
    for (int k = 1; k < nrd; k++)
    begin
      rd_take <= 1'b1;
      @(posedge clk);
      rd_take <= 1'b0;
      @(posedge clk);
      rb[8*k +: 8] = rd_data;
    end
    frame_commit <= commit;
    frame_abort <= !commit;
    @(posedge clk);
    frame_commit <= 1'b0;
    frame_abort <= 1'b0;
  endtask

  // hold the wire low for n cycles
  task automatic hold_low(input int n);
    @(posedge clk);
    link_low <= 1'b1;
    repeat (n) @(posedge clk);
    link_low <= 1'b0;
  endtask
endmodule
`default_nettype wire

// ### testbench/serial_mailbox_request_response_tb_top.sv
// self-checking bench for the mailbox responder
`timescale 1ns/1ns
`default_nettype none
module serial_mailbox_request_response_tb_top;
  import mailbox_pkg::*;
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic frame_start, wr_valid, wr_end, rd_take, frame_commit, frame_abort, link_low;
  logic [7:0] wr_byte, rd_data, svc_type;
  logic rd_valid, abort_fcs, svc_req, locked;
  logic [31:0] svc_payload;
  logic [3:0] tid;
  logic svc_done = 1'b0;
  svc_status_t svc_status = SVC_OK;
  logic [31:0] svc_data = 32'h0;
  logic mbx_unavailable = 1'b0;
  logic reset_or_sleep = 1'b0;
  logic timeout_disable = 1'b0;
  logic [3:0] exp_tid = 4'h0;
  logic [39:0] r;
  int n_fail = 0;
  int check_count = 0;
  int cycles = 0;

  // ----------------------------------------
  // clock, design and far side
  // ----------------------------------------
  always #20 clk = ~clk;

  mailbox_responder #(.TIMEOUT_CYCLES(20)) DUT (.clk(clk), .reset_n(reset_n), .frame_start(frame_start),
    .wr_valid(wr_valid), .wr_byte(wr_byte), .wr_end(wr_end), .rd_take(rd_take), .frame_commit(frame_commit),
    .frame_abort(frame_abort), .rd_data(rd_data), .rd_valid(rd_valid), .abort_fcs(abort_fcs),
    .svc_req(svc_req), .svc_type(svc_type), .svc_payload(svc_payload), .svc_done(svc_done),
    .svc_status(svc_status), .svc_data(svc_data), .mbx_unavailable(mbx_unavailable),
    .reset_or_sleep(reset_or_sleep), .timeout_disable(timeout_disable), .link_low(link_low),
    .locked(locked), .tid(tid));

  host_model host (.clk(clk), .frame_start(frame_start), .wr_valid(wr_valid), .wr_byte(wr_byte),
    .wr_end(wr_end), .rd_take(rd_take), .frame_commit(frame_commit), .frame_abort(frame_abort),
    .link_low(link_low), .rd_data(rd_data), .rd_valid(rd_valid), .abort_fcs(abort_fcs));

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("Error at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  // frame checksum over command code, type and payload, msb first
  function automatic logic [7:0] crc8(input logic [47:0] m);
    logic [7:0] c;
    c = CRC_INIT;
    for (int i = 0; i < 6; i++)
    begin
      c = c ^ m[8*i +: 8];
      for (int j = 0; j < 8; j++)
        c = c[7] ? ((c << 1) ^ CRC_POLY) : (c << 1);
    end
    return c;
  endfunction

  task automatic req(input logic [7:0] typ, input logic [31:0] pay, input logic bad, input logic commit,
    output logic [7:0] cc, output logic ab);
    logic [63:0] w;
    logic [39:0] rb;
    logic v;
    w = {8'h00, 8'h00, {pay, typ, CMD_REQUEST}};
    w[55:48] = crc8(w[47:0]) ^ {7'h00, bad};
    host.frame(w, 7, 1, commit, rb, ab, v);
    chk(32'(v), 32'h1);
    cc = rb[7:0];
  endtask

  task automatic get(input logic [7:0] id, input logic commit, input logic exp_ab, input logic [7:0] exp_cc);
    logic ab;
    logic v;
    host.frame({48'h0, id, CMD_RESPONSE}, 2, 5, commit, r, ab, v);
    chk(32'(ab), 32'(exp_ab));
    if (!exp_ab)
      chk(32'(r[7:0]), 32'(exp_cc));
  endtask

  task automatic grant(input logic [7:0] typ, input logic [31:0] pay);
    logic [7:0] cc;
    logic ab;
    req(typ, pay, 1'b0, 1'b1, cc, ab);
    exp_tid = exp_tid + 4'h1;
    chk(32'(ab), 32'h0);
    chk(32'(cc), 32'({CC_GRANT_HI, exp_tid}));
    @(posedge clk);
    chk(32'(locked), 32'h1);
    chk(32'(tid), 32'(exp_tid));
    chk(32'(svc_req), 32'h1);
    chk({24'h0, svc_type}, 32'(typ));
    chk(svc_payload, pay);
  endtask

  task automatic serve(input svc_status_t s, input logic [31:0] d);
    @(posedge clk);
    svc_status <= s;
    svc_data <= d;
    svc_done <= 1'b1;
    @(posedge clk);
    svc_done <= 1'b0;
    svc_data <= ~d;
  endtask

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_busy();
    logic [7:0] cc;
    logic ab;
    grant(8'h0f, 32'h44332211);
    req(8'h05, 32'h0, 1'b0, 1'b1, cc, ab);
    chk(32'(cc), 32'(CC_BUSY));
    @(posedge clk);
    chk(32'(tid), 32'(exp_tid));
  endtask

  task automatic t_release();
    get(exp_tid + 4'h1, 1'b1, 1'b0, CC_BAD_TID);
    get({4'h1, exp_tid}, 1'b1, 1'b0, CC_BAD_TID);
    get(exp_tid, 1'b1, 1'b1, 8'h00);
    serve(SVC_OK, 32'ha1b2c3d4);
    get(exp_tid, 1'b0, 1'b0, CC_PASS);
    @(posedge clk);
    chk(32'(locked), 32'h1);
    get(exp_tid, 1'b1, 1'b0, CC_PASS);
    chk(r[39:8], 32'ha1b2c3d4);
    @(posedge clk);
    chk(32'(locked), 32'h0);
  endtask

  task automatic t_codes();
    logic [7:0] exp_cc [8];
    exp_cc = '{8'h40, 8'h81, 8'h82, 8'h83, 8'h84, 8'h88, 8'h89, 8'hff};
    for (int i = 0; i < 8; i++)
    begin
      grant(8'h10 + 8'(i), 32'(i));
      serve(svc_status_t'(i), 32'h0);
      get(exp_tid, 1'b1, 1'b0, exp_cc[i]);
    end
  endtask

  task automatic t_bad_frames();
    logic [7:0] cc;
    logic ab;
    req(8'h01, 32'h12345678, 1'b1, 1'b1, cc, ab);
    chk(32'(ab), 32'h1);
    host.frame({40'h0, 8'h00, 8'h01, CMD_RESPONSE}, 3, 5, 1'b1, r, ab, cc[0]);
    chk(32'(ab), 32'h1);
    req(8'h02, 32'h0, 1'b0, 1'b0, cc, ab);
    chk(32'(cc), 32'({CC_GRANT_HI, exp_tid + 4'h1}));
    @(posedge clk);
    chk(32'(locked), 32'h0);
    get(exp_tid + 4'h1, 1'b1, 1'b0, CC_BAD_TID);
  endtask

  task automatic t_sleep();
    logic [7:0] cc;
    logic ab;
    @(posedge clk);
    reset_or_sleep <= 1'b1;
    req(8'h01, 32'h0, 1'b0, 1'b1, cc, ab);
    chk(32'(cc), 32'(CC_TIMEOUT));
    get(exp_tid, 1'b1, 1'b0, CC_TIMEOUT);
    reset_or_sleep <= 1'b0;
    mbx_unavailable <= 1'b1;
    req(8'h01, 32'h0, 1'b0, 1'b1, cc, ab);
    chk(32'(cc), 32'(CC_BUSY));
    get(exp_tid, 1'b1, 1'b0, CC_BUSY);
    mbx_unavailable <= 1'b0;
  endtask

  task automatic t_timeout();
    grant(8'h03, 32'h0);
    host.hold_low(15);
    repeat (4) @(posedge clk);
    chk(32'(locked), 32'h1);
    host.hold_low(4);
    repeat (4) @(posedge clk);
    chk(32'(locked), 32'h1);
    host.hold_low(1);
    repeat (4) @(posedge clk);
    chk(32'(locked), 32'h0);
    get(exp_tid, 1'b1, 1'b0, CC_BAD_TID);
    timeout_disable <= 1'b1;
    grant(8'h04, 32'h0);
    host.hold_low(40);
    repeat (4) @(posedge clk);
    chk(32'(locked), 32'h1);
    serve(SVC_OK, 32'h0);
    get(exp_tid, 1'b1, 1'b0, CC_PASS);
    timeout_disable <= 1'b0;
  endtask

  // ----------------------------------------
  // main sequence and hang guard
  // ----------------------------------------
  initial
  begin
    repeat (8) @(posedge clk);
    reset_n <= 1'b1;
    @(posedge clk);
    chk(32'(locked), 32'h0);
    chk(32'(tid), 32'h0);
    t_busy();
    t_release();
    t_codes();
    t_bad_frames();
    t_sleep();
    t_timeout();
    end_of_test();
  end

  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 6000)
    begin
      n_fail++;
      end_of_test();
    end
  end
endmodule
`default_nettype wire
